// File: hdl/mca_defs.vh
// Constants for the multichannel alignment control block.
// Assumes a Wishbone classic slave with 32-bit data and word addressing
// (byte address = register index times four).
//
// What this block does
// - Mode field 00 none, 10 twin, 01 quad, 11 eight.
// - Two twin pairs per quad, both quads alike.
// - Member enable 1 joins group, 0 excludes.
// - Seven group resync bits: octet, quads, four pairs.
// - Resync fires only on command rising edge.
// - Single resync resets channel FIFO pointers.
// - Soft reset bit holds the SERDES reset level.
// - Protocol bit 1 XAUI, default 0 Fibre.
// - Per-quad rx and tx clock source fields.
// - Alarm register shows PLL lock flag.
// - Link state reads 10 once synchronised.
// - Word align done bit reads 1 when aligned.
// - Group align done set on completion, resync clears.
// - Word realign restarts on command rising edge.
// - Desync and overrun flags per group, three registers.
// - Headroom threshold resets to zero.
// - Counter from 18, step 1, then 2 once all seen.
// - At zero start reading; missing members flag desync.
// - Overrun when member headroom below threshold.
// - Ungrouped channel sets FIFO pointers on first character.
`ifndef MCA_DEFS_VH
`define MCA_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------
`define MCA_IDX_ALARM0 18'h30000
`define MCA_IDX_ALARM1 18'h30010
`define MCA_IDX_ALARM2 18'h30020
`define MCA_IDX_ALARM3 18'h30030
`define MCA_IDX_ALARM4 18'h30100
`define MCA_IDX_ALARM5 18'h30110
`define MCA_IDX_ALARM6 18'h30120
`define MCA_IDX_ALARM7 18'h30130
`define MCA_IDX_A_LINK 18'h30804
`define MCA_IDX_A_STAT 18'h30805
`define MCA_IDX_A_MEMB 18'h30810
`define MCA_IDX_A_MODE 18'h30811
`define MCA_IDX_A_ERR 18'h30814
`define MCA_IDX_A_PROT 18'h30820
`define MCA_IDX_B_LINK 18'h30904
`define MCA_IDX_B_STAT 18'h30905
`define MCA_IDX_B_MEMB 18'h30910
`define MCA_IDX_B_MODE 18'h30911
`define MCA_IDX_B_ERR 18'h30914
`define MCA_IDX_B_PROT 18'h30920
`define MCA_IDX_CLKSEL 18'h30A00
`define MCA_IDX_GRESYNC 18'h30A02
`define MCA_IDX_GERR 18'h30A03
`define MCA_IDX_MISC 18'h30A04

// ----------------------------------------------------------------
// Group mode encodings and group indices
// ----------------------------------------------------------------
`define MCA_MODE_NONE 2'h0
`define MCA_MODE_QUAD 2'h1
`define MCA_MODE_TWIN 2'h2
`define MCA_MODE_OCTET 2'h3
`define MCA_G_OCTET 3'h0
`define MCA_G_QUAD_A 3'h1
`define MCA_G_QUAD_B 3'h2
`define MCA_G_PAIR0 3'h3

// ----------------------------------------------------------------
// Sync counter and reset values
// ----------------------------------------------------------------
`define MCA_SYNC_START 5'h12
`define MCA_STEP_ONE 5'h01
`define MCA_STEP_TWO 5'h02
`define MCA_HEADROOM_RST 4'h0
`define MCA_REG_RST 8'h00

`endif

// File: hdl/mca_align_ctrl.v
// Multichannel alignment control and status for two four-channel quads.
// Assumes a Wishbone classic master on clk_i and a receive datapath on
// the same clock giving alignment-character strobes and FIFO headroom;
// SERDES status levels arrive asynchronously and are synchronised here.
//
// Added by the designer: register access over Wishbone.
`include "mca_defs.vh"

module mca_align_ctrl (
  input wire clk_i,
  input wire rst_i,
  input wire [19:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  output wire wb_ack_o,
  input wire [7:0] pll_lock_flag_i,
  input wire [15:0] lane_link_state_i,
  input wire [7:0] word_align_done_i,
  input wire [7:0] align_char_i,
  input wire [31:0] fifo_headroom_i,
  output wire serdes_soft_reset_o,
  output wire [7:0] lane_protocol_select_o,
  output wire [3:0] rx_clock_source_sel_o,
  output wire [3:0] tx_clock_source_sel_o,
  output wire [7:0] word_realign_o,
  output wire [7:0] fifo_ptr_reset_o,
  output wire [7:0] fifo_ptr_init_o,
  output wire [7:0] fifo_read_en_o
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg [7:0] memb_a_q; // Member enables [3:0], realign [7:4]
  reg [7:0] memb_b_q;
  reg [7:0] mode_a_q; // Two bits per channel
  reg [7:0] mode_b_q;
  reg [7:0] prot_a_q; // Protocol [3:0], single resync [7:4]
  reg [7:0] prot_b_q;
  reg [7:0] clksel_q; // Rx A, rx B, tx A, tx B
  reg [7:0] gresync_q; // Seven group resync bits
  reg soft_rst_q; // SERDES soft reset level
  reg [3:0] headroom_min_q; // Least FIFO headroom

  // Bus slave state
  reg ack_q;
  reg [31:0] rdat_q;
  reg [7:0] rd_val;

  // Synchroniser stages for SERDES status levels
  reg [31:0] meta_q; // First stage, read only by second
  reg [31:0] stat_q; // Second stage, safe to use

  // Command edge detection
  reg [22:0] cmd_prev_q;
  reg [22:0] cmd_pulse_q;

  // Derived per-channel and per-group vectors
  wire [22:0] cmd_v;
  wire [7:0] real_p;
  wire [7:0] single_p;
  wire [6:0] grs_p;
  wire [7:0] pll_s;
  wire [15:0] link_s;
  wire [7:0] wad_s;
  wire [7:0] member_enable;
  wire [15:0] group_mode_sel;
  wire [7:0] in_grp;
  wire [23:0] gid_v; // Three bits per channel
  wire [7:0] low_v; // Headroom below threshold
  wire [7:0] chan_rs;
  wire [6:0] done_v;
  wire [6:0] desync_v;
  wire [6:0] overrun_v;
  wire [7:0] grp_done_ch;
  wire [55:0] mask_v; // Eight member bits per group

  // Per-channel output flops
  reg [7:0] init_armed_q;
  reg [7:0] ptr_init_q;
  reg [7:0] read_en_q;
  reg [7:0] ptr_rst_q;

  wire [17:0] idx;
  wire req;

  assign idx = wb_adr_i[19:2];
  assign req = wb_cyc_i & wb_stb_i;

  assign member_enable = {memb_b_q[3:0], memb_a_q[3:0]};
  assign group_mode_sel = {mode_b_q, mode_a_q};

  // ----------------------------------------------------------------
  // Wishbone slave: ack one cycle after request, write at ack edge
  // ----------------------------------------------------------------
  // Acking a cycle late lets read data come straight from a flop.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      rdat_q <= {24'h000000, rd_val};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Read multiplexer; unmapped indices read as zero
  always @* begin
    case (idx)
      `MCA_IDX_ALARM0: rd_val = {7'h00, pll_s[0]};
      `MCA_IDX_ALARM1: rd_val = {7'h00, pll_s[1]};
      `MCA_IDX_ALARM2: rd_val = {7'h00, pll_s[2]};
      `MCA_IDX_ALARM3: rd_val = {7'h00, pll_s[3]};
      `MCA_IDX_ALARM4: rd_val = {7'h00, pll_s[4]};
      `MCA_IDX_ALARM5: rd_val = {7'h00, pll_s[5]};
      `MCA_IDX_ALARM6: rd_val = {7'h00, pll_s[6]};
      `MCA_IDX_ALARM7: rd_val = {7'h00, pll_s[7]};
      `MCA_IDX_A_LINK: rd_val = link_s[7:0];
      `MCA_IDX_B_LINK: rd_val = link_s[15:8];
      // Word align [3:0] and group align [7:4]
      `MCA_IDX_A_STAT: rd_val = {grp_done_ch[3:0], wad_s[3:0]};
      `MCA_IDX_B_STAT: rd_val = {grp_done_ch[7:4], wad_s[7:4]};
      `MCA_IDX_A_MEMB: rd_val = memb_a_q;
      `MCA_IDX_B_MEMB: rd_val = memb_b_q;
      `MCA_IDX_A_MODE: rd_val = mode_a_q;
      `MCA_IDX_B_MODE: rd_val = mode_b_q;
      // Quad, low pair, high pair: desync then overrun
      `MCA_IDX_A_ERR: rd_val = {2'h0, overrun_v[4], desync_v[4], overrun_v[3],
        desync_v[3], overrun_v[1], desync_v[1]};
      `MCA_IDX_B_ERR: rd_val = {2'h0, overrun_v[6], desync_v[6], overrun_v[5],
        desync_v[5], overrun_v[2], desync_v[2]};
      `MCA_IDX_GERR: rd_val = {6'h00, overrun_v[0], desync_v[0]};
      `MCA_IDX_A_PROT: rd_val = prot_a_q;
      `MCA_IDX_B_PROT: rd_val = prot_b_q;
      `MCA_IDX_CLKSEL: rd_val = clksel_q;
      `MCA_IDX_GRESYNC: rd_val = gresync_q;
      `MCA_IDX_MISC: rd_val = {headroom_min_q, 3'h0, soft_rst_q};
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes, low byte lane only
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      memb_a_q <= `MCA_REG_RST;
      memb_b_q <= `MCA_REG_RST;
      mode_a_q <= `MCA_REG_RST;
      mode_b_q <= `MCA_REG_RST;
      prot_a_q <= `MCA_REG_RST; // Fibre Channel by default
      prot_b_q <= `MCA_REG_RST;
      clksel_q <= `MCA_REG_RST;
      gresync_q <= `MCA_REG_RST;
      soft_rst_q <= 1'b0;
      headroom_min_q <= `MCA_HEADROOM_RST;
    end else if (req & ack_q & wb_we_i & wb_sel_i[0]) begin
      case (idx)
        `MCA_IDX_A_MEMB: memb_a_q <= wb_dat_i[7:0];
        `MCA_IDX_B_MEMB: memb_b_q <= wb_dat_i[7:0];
        `MCA_IDX_A_MODE: mode_a_q <= wb_dat_i[7:0];
        `MCA_IDX_B_MODE: mode_b_q <= wb_dat_i[7:0];
        `MCA_IDX_A_PROT: prot_a_q <= wb_dat_i[7:0];
        `MCA_IDX_B_PROT: prot_b_q <= wb_dat_i[7:0];
        `MCA_IDX_CLKSEL: clksel_q <= wb_dat_i[7:0];
        `MCA_IDX_GRESYNC: gresync_q <= {1'b0, wb_dat_i[6:0]};
        `MCA_IDX_MISC: begin
          soft_rst_q <= wb_dat_i[0];
          headroom_min_q <= wb_dat_i[7:4];
        end
        // Read-only and unmapped indices ignore writes
        default: soft_rst_q <= soft_rst_q;
      endcase
    end
  end

  // Static configuration straight from the registers
  assign serdes_soft_reset_o = soft_rst_q; // SERDES held while bit is 1
  assign lane_protocol_select_o = {prot_b_q[3:0], prot_a_q[3:0]};
  assign rx_clock_source_sel_o = clksel_q[3:0];
  assign tx_clock_source_sel_o = clksel_q[7:4];

  // ----------------------------------------------------------------
  // Two-flop synchronisers for SERDES status levels
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 32'h00000000;
      stat_q <= 32'h00000000;
    end else begin
      meta_q <= {word_align_done_i, lane_link_state_i, pll_lock_flag_i};
      stat_q <= meta_q;
    end
  end

  assign pll_s = stat_q[7:0];
  assign link_s = stat_q[23:8];
  assign wad_s = stat_q[31:24];

  // ----------------------------------------------------------------
  // Command rising edges to one-cycle pulses
  // ----------------------------------------------------------------
  // Rewriting 1 over 1 gives no edge, so software must write 0 first.
  assign cmd_v = {gresync_q[6:0], prot_b_q[7:4], prot_a_q[7:4],
    memb_b_q[7:4], memb_a_q[7:4]};

  always @(posedge clk_i) begin
    if (rst_i) begin
      cmd_prev_q <= 23'h000000;
      cmd_pulse_q <= 23'h000000;
    end else begin
      cmd_prev_q <= cmd_v;
      cmd_pulse_q <= cmd_v & ~cmd_prev_q;
    end
  end

  assign real_p = cmd_pulse_q[7:0];
  assign single_p = cmd_pulse_q[15:8];
  assign grs_p = cmd_pulse_q[22:16];
  assign word_realign_o = real_p;

  // ----------------------------------------------------------------
  // Per-channel group selection, pointers and read enable
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1) begin : gen_chan
      wire [1:0] mode;
      reg [2:0] gid;
      reg grouped;

      assign mode = group_mode_sel[2*c+1:2*c];

      // Decode the channel's group from its mode field
      always @* begin
        grouped = member_enable[c];
        case (mode)
          `MCA_MODE_OCTET: gid = `MCA_G_OCTET;
          `MCA_MODE_QUAD: gid = (c < 4) ? `MCA_G_QUAD_A : `MCA_G_QUAD_B;
          // Pairs AB and CD in each quad
          // Genvar bits cannot be selected, so the pair index is spelled out
          `MCA_MODE_TWIN: gid = (c < 2) ? 3'h3 : (c < 4) ? 3'h4 : (c < 6) ? 3'h5 : 3'h6;
          default: begin
            gid = `MCA_G_OCTET;
            grouped = 1'b0; // No alignment
          end
        endcase
      end

      assign in_grp[c] = grouped;
      assign gid_v[3*c+2:3*c] = gid;
      // Headroom under threshold counts as overrun
      assign low_v[c] = fifo_headroom_i[4*c+3:4*c] < headroom_min_q;
      // Own command or own group's resync
      assign chan_rs[c] = single_p[c] | (grouped & grs_p[gid]);
      assign grp_done_ch[c] = grouped ? done_v[gid] : ~init_armed_q[c];

      // Ungrouped channel: place pointers on first character
      always @(posedge clk_i) begin
        if (rst_i | chan_rs[c]) begin
          init_armed_q[c] <= 1'b1;
          ptr_init_q[c] <= 1'b0;
        end else if (init_armed_q[c] & ~grouped & align_char_i[c]) begin
          init_armed_q[c] <= 1'b0;
          ptr_init_q[c] <= 1'b1; // Write at start, read at middle
        end else begin
          ptr_init_q[c] <= 1'b0;
        end
      end

      // Pointer reset pulse and read enable
      always @(posedge clk_i) begin
        if (rst_i) begin
          ptr_rst_q[c] <= 1'b0;
          read_en_q[c] <= 1'b0;
        end else begin
          ptr_rst_q[c] <= chan_rs[c];
          read_en_q[c] <= grp_done_ch[c];
        end
      end
    end
  endgenerate

  assign fifo_ptr_reset_o = ptr_rst_q;
  assign fifo_ptr_init_o = ptr_init_q;
  assign fifo_read_en_o = read_en_q;

  // ----------------------------------------------------------------
  // Per-group sync down-counter and flags
  // ----------------------------------------------------------------
  // The count runs once per resync; it does not restart on its own.
  genvar g;
  genvar m;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gen_grp
      wire [7:0] mask;
      wire [7:0] hit;
      wire [7:0] seen_n;
      wire all_seen;
      wire [4:0] step;
      reg [4:0] cnt_q;
      reg [7:0] seen_q;
      reg run_q;
      reg done_q;
      reg desync_q;
      reg overrun_q;

      for (m = 0; m < 8; m = m + 1) begin : gen_mask
        assign mask[m] = in_grp[m] & (gid_v[3*m+2:3*m] == g);
      end

      assign mask_v[8*g+7:8*g] = mask;
      assign hit = align_char_i & mask;
      assign seen_n = seen_q | hit;
      assign all_seen = ((mask & ~seen_n) == 8'h00);
      // Step one until every member has shown its character
      assign step = all_seen ? `MCA_STEP_TWO : `MCA_STEP_ONE;

      always @(posedge clk_i) begin
        if (rst_i | grs_p[g]) begin
          cnt_q <= `MCA_SYNC_START;
          seen_q <= 8'h00;
          run_q <= 1'b0;
          done_q <= 1'b0; // Resync clears completion
          desync_q <= 1'b0;
        end else if (~done_q & (run_q | (|hit))) begin
          run_q <= 1'b1;
          seen_q <= seen_n;
          if (cnt_q <= step) begin
            cnt_q <= 5'h00;
            done_q <= 1'b1;
            desync_q <= ~all_seen;
          end else begin
            cnt_q <= cnt_q - step;
          end
        end
      end

      // Live overrun so lowering the threshold clears it
      always @(posedge clk_i) begin
        if (rst_i) begin
          overrun_q <= 1'b0;
        end else begin
          overrun_q <= |(mask & low_v);
        end
      end

      assign done_v[g] = done_q;
      assign desync_v[g] = desync_q;
      assign overrun_v[g] = overrun_q;
    end
  endgenerate

endmodule // mca_align_ctrl

// File: tb/mca_lane_model.sv
// Receive-lane model: alignment-character strobes per lane.
// Assumes the bench clock; the bench picks the lanes that send.
module mca_lane_model (
  input wire clk_i,
  input wire [7:0] en_i,
  output logic [7:0] char_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // Column generator
  // ----------------
  logic [2:0] ph_q = 3'h0; // Column phase, free running
  // One column every 8 cycles, so all lanes are seen together
  always @(posedge clk_i) begin
    ph_q <= ph_q + 3'h1;
    char_o <= (ph_q == 3'h0) ? en_i : 8'h00;
  end
endmodule // mca_lane_model

// File: tb/mca_align_properties.sv
// Port checker of the alignment control block.
// Assumes one clock and a synchronous active-high reset.
`include "mca_defs.vh"
module mca_align_properties (
  input wire clk_i,
  input wire rst_i,
  input wire [19:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  input wire wb_ack_o,
  input wire [7:0] align_char_i,
  input wire serdes_soft_reset_o,
  input wire [7:0] lane_protocol_select_o,
  input wire [3:0] rx_clock_source_sel_o,
  input wire [3:0] tx_clock_source_sel_o,
  input wire [7:0] word_realign_o,
  input wire [7:0] fifo_ptr_reset_o,
  input wire [7:0] fifo_ptr_init_o
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Request still waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Write taken at the edge that sees ack
  sequence s_wr(idx);
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i[19:2] == idx;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_clk_select: assert property (
    s_wr(`MCA_IDX_CLKSEL) |=>
      {tx_clock_source_sel_o, rx_clock_source_sel_o} == $past(wb_dat_i[7:0]))
    else $error("clock selects differ from write");
  a_proto_select: assert property (
    s_wr(`MCA_IDX_B_PROT) |=> lane_protocol_select_o[7:4] == $past(wb_dat_i[3:0]))
    else $error("protocol select differs from write");
  a_soft_reset: assert property (
    s_wr(`MCA_IDX_MISC) |=> serdes_soft_reset_o == $past(wb_dat_i[0]))
    else $error("soft reset differs from write");
  a_realign_pulse: assert property (
    (word_realign_o & $past(word_realign_o)) == 8'h00)
    else $error("realign pulse longer than one cycle");
  a_ptr_pulse: assert property (
    (fifo_ptr_reset_o & $past(fifo_ptr_reset_o)) == 8'h00)
    else $error("pointer reset longer than one cycle");
  a_realign_cause: assert property (
    word_realign_o[0] |-> $past(wb_ack_o && wb_we_i && wb_dat_i[4]
      && wb_adr_i[19:2] == `MCA_IDX_A_MEMB, 2))
    else $error("realign pulse without command");
  a_init_cause: assert property (
    (fifo_ptr_init_o & ~$past(align_char_i)) == 8'h00)
    else $error("pointer init without character");
endmodule // mca_align_properties

// File: tb/mca_align_ctrl_tb.sv
// Bench of the alignment control block: bus master, lanes, scoreboard.
// Assumes the design header on the include path.
`include "mca_defs.vh"
module mca_align_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [19:0] wb_adr_i = 20'h00000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic [7:0] lock = 8'h00; // Lane status levels
  logic [15:0] link = 16'h0;
  logic [7:0] wad = 8'h00;
  logic [7:0] char_en = 8'h00; // Lanes that send characters
  logic [31:0] hr = 32'h88888888; // Headroom, well above threshold
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [7:0] align_char_i, realign, ptr_rst, ptr_init, rd_en;
  logic [31:0] exp_q[$], msk_q[$], m;
  logic [7:0] ptr_seen = 8'h00, init_seen = 8'h00, r;
  int error_cnt = 0, cmp_count = 0, rl_cnt = 0;
  // Modes A, B and expected member mask per group resync bit
  logic [23:0] gt [7] = '{24'hFFFFFF, 24'h55000F, 24'h0055F0, 24'h0A0003,
    24'hA0000C, 24'h000A30, 24'h00A0C0};
  always #5 clk_i = ~clk_i;
  mca_lane_model lanes_u (.clk_i(clk_i), .en_i(char_en), .char_o(align_char_i));
  mca_align_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
    .pll_lock_flag_i(lock), .lane_link_state_i(link), .word_align_done_i(wad),
    .align_char_i(align_char_i), .fifo_headroom_i(hr), .serdes_soft_reset_o(),
    .lane_protocol_select_o(), .rx_clock_source_sel_o(), .tx_clock_source_sel_o(),
    .word_realign_o(realign), .fifo_ptr_reset_o(ptr_rst), .fifo_ptr_init_o(ptr_init),
    .fifo_read_en_o(rd_en));
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic we, input logic [17:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk("ack_wait", 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] idx, input logic [7:0] e, input logic [7:0] k);
    exp_q.push_back({24'h0, e});
    msk_q.push_back({24'hFFFFFF, k}); // Upper bits must read zero
    bus(1'b0, idx, 8'h00);
  endtask
  // Scoreboard for read answers, plus pulse bookkeeping
  always @(posedge clk_i) begin
    rl_cnt += realign[0];
    ptr_seen |= ptr_rst;
    init_seen |= ptr_init;
    if (wb_ack_o && wb_cyc_i && !wb_we_i && msk_q.size() > 0) begin
      m = msk_q.pop_front();
      chk("read", wb_dat_o & m, exp_q.pop_front() & m);
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    results();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    void'($urandom(32'heb15c596));
    @(posedge clk_i);
    lock <= $urandom;
    link <= $urandom;
    wad <= $urandom;
    r = $urandom;
    repeat (19) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`MCA_IDX_MISC, 8'h00, 8'hFF);
    rd(`MCA_IDX_A_PROT, 8'h00, 8'hFF);
    for (int i = 0; i < 8; i++)
      rd(18'h30000 + 18'h100 * (i / 4) + 18'h10 * (i % 4), {7'h0, lock[i]}, 8'h01);
    rd(`MCA_IDX_A_LINK, link[7:0], 8'hFF);
    rd(`MCA_IDX_B_LINK, link[15:8], 8'hFF);
    rd(`MCA_IDX_A_STAT, {4'h0, wad[3:0]}, 8'h0F);
    rd(`MCA_IDX_B_STAT, {4'h0, wad[7:4]}, 8'h0F);
    rd(18'h30A05, 8'h00, 8'hFF);
    // Ungrouped lanes place pointers on first character
    char_en <= 8'hFF;
    repeat (12) @(posedge clk_i);
    chk("ptr_init", init_seen, 8'hFF);
    chk("read_en", rd_en, 8'hFF);
    char_en <= 8'h00;
    bus(1'b1, `MCA_IDX_CLKSEL, r);
    rd(`MCA_IDX_CLKSEL, r, 8'hFF);
    bus(1'b1, `MCA_IDX_B_PROT, 8'h05);
    bus(1'b1, `MCA_IDX_A_ERR, 8'hFF);
    rd(`MCA_IDX_A_ERR, 8'h00, 8'hFF);
    bus(1'b1, `MCA_IDX_MISC, 8'h01);
    bus(1'b1, `MCA_IDX_MISC, 8'h00);
    // Realign written twice: a repeated 1 must not fire again
    bus(1'b1, `MCA_IDX_A_MEMB, 8'h0F);
    rl_cnt = 0;
    bus(1'b1, `MCA_IDX_A_MEMB, 8'h1F);
    bus(1'b1, `MCA_IDX_A_MEMB, 8'h1F);
    repeat (4) @(posedge clk_i);
    chk("realign", rl_cnt, 1);
    ptr_seen = 8'h00;
    bus(1'b1, `MCA_IDX_A_PROT, 8'h20);
    repeat (4) @(posedge clk_i);
    chk("single", ptr_seen, 8'h02);
    // Group and mode setup stands in the settle time after soft reset
    bus(1'b1, `MCA_IDX_B_MEMB, 8'h0F);
    // Every group mode and resync bit in turn
    for (int g = 0; g < 7; g++) begin
      bus(1'b1, `MCA_IDX_A_MODE, gt[g][23:16]);
      bus(1'b1, `MCA_IDX_B_MODE, gt[g][15:8]);
      bus(1'b1, `MCA_IDX_GRESYNC, 8'h00);
      ptr_seen = 8'h00;
      bus(1'b1, `MCA_IDX_GRESYNC, 8'h01 << g);
      repeat (4) @(posedge clk_i);
      chk("grp_reset", ptr_seen, gt[g][7:0]);
      rd(`MCA_IDX_A_STAT, 8'h00, {gt[g][3:0], 4'h0});
      char_en <= gt[g][7:0];
      repeat (40) @(posedge clk_i);
      char_en <= 8'h00;
      rd(`MCA_IDX_A_STAT, {gt[g][3:0], 4'h0}, {gt[g][3:0], 4'h0});
      rd(`MCA_IDX_B_STAT, {gt[g][7:4], 4'h0}, {gt[g][7:4], 4'h0});
      rd(`MCA_IDX_A_ERR, 8'h00, 8'hFF);
      rd(`MCA_IDX_B_ERR, 8'h00, 8'hFF);
      rd(`MCA_IDX_GERR, 8'h00, 8'hFF);
    end
    // Quad A with one silent lane, then headroom fault and recovery
    bus(1'b1, `MCA_IDX_A_MODE, 8'h55);
    bus(1'b1, `MCA_IDX_GRESYNC, 8'h00);
    bus(1'b1, `MCA_IDX_GRESYNC, 8'h02);
    char_en <= 8'h07;
    repeat (40) @(posedge clk_i);
    char_en <= 8'h00;
    rd(`MCA_IDX_A_ERR, 8'h01, 8'hFF);
    hr <= 32'h88888882;
    bus(1'b1, `MCA_IDX_MISC, 8'h40);
    rd(`MCA_IDX_A_ERR, 8'h03, 8'hFF);
    bus(1'b1, `MCA_IDX_MISC, 8'h00);
    rd(`MCA_IDX_A_ERR, 8'h01, 8'hFF);
    bus(1'b1, `MCA_IDX_A_MEMB, 8'h0F);
    bus(1'b1, `MCA_IDX_A_MEMB, 8'h1F);
    bus(1'b1, `MCA_IDX_GRESYNC, 8'h00);
    bus(1'b1, `MCA_IDX_GRESYNC, 8'h02);
    char_en <= 8'h0F;
    repeat (40) @(posedge clk_i);
    rd(`MCA_IDX_A_ERR, 8'h00, 8'hFF);
    results();
  end
endmodule // mca_align_ctrl_tb

bind mca_align_ctrl mca_align_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .align_char_i(align_char_i), .serdes_soft_reset_o(serdes_soft_reset_o),
  .lane_protocol_select_o(lane_protocol_select_o),
  .rx_clock_source_sel_o(rx_clock_source_sel_o),
  .tx_clock_source_sel_o(tx_clock_source_sel_o), .word_realign_o(word_realign_o),
  .fifo_ptr_reset_o(fifo_ptr_reset_o), .fifo_ptr_init_o(fifo_ptr_init_o));
